/* src/cds_status_top.sv */
// Purpose: Cable diagnostics status readout at register index 31, Avalon-MM slave
// Assumes: Test engine and link logic run on I_MCLK; no synchroniser needed
// Notes:   Every access takes one wait cycle; read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"

// Behaviour
// (RULE_01) Bit 10 flags reported pair shorted to A
// (RULE_02) Reads cycle pairs A, B, C, D, wrap
// (RULE_03) Distance is meters; all ones means unknown
// (RULE_04) Distance sits in bits 9:2, first fault
// (RULE_05) Software picks first reported pair, index 30
// (RULE_06) Bits 1:0 name the reported pair
// (RULE_07) Linking enabled selects the link-state layout
// (RULE_08) Bit 14 shows C/D swap, gigabit only
// (RULE_09) Bits 13:12 polarity D, C, gigabit only
// (RULE_10) Bits 11:10 polarity B, A, 10M/gigabit
// (RULE_11) Link view bits 9:2 cable length, FF unknown
// (RULE_12) Bit 0 latches descrambler acquisition failure
// (RULE_13) Skew failure requests fallback to lower speed
// (RULE_14) Bits 15:14 give the fault type
// (RULE_15) Invalid fault type forces distance all ones
// (RULE_16) Bits 13:11 flag shorts to D, C, B
// (RULE_17) Pointer advances only after whole read
module cds_status_top (
    input  wire logic                   I_MCLK,             // 125 MHz management clock
    input  wire logic                   I_RST,              // Synchronous reset, high
    input  wire logic [`CDS_ADDR_W-1:0] I_AVS_ADDRESS,      // Byte address
    input  wire logic                   I_AVS_READ,         // Read request
    input  wire logic                   I_AVS_WRITE,        // Write request
    input  wire logic [31:0]            I_AVS_WRITEDATA,    // Write data
    input  wire logic [3:0]             I_AVS_BYTEENABLE,   // Byte lanes
    output logic      [31:0]            O_AVS_READDATA,     // Read data
    output logic                        O_AVS_WAITREQUEST,  // Stall
    input  wire logic                   I_LINK_EN,          // Linking enabled
    input  wire logic                   I_TDR_DONE,         // Analysis completed pulse
    input  wire logic [7:0]             I_TDR_FAULT_TYPE,   // 2 bits per pair, A low
    input  wire logic [15:0]            I_TDR_SHORTS,       // 4 bits per pair: D,C,B,A
    input  wire logic [31:0]            I_TDR_RANGE,        // 8-bit meters per pair
    input  wire logic                   I_GIG_MODE,         // Running 1000BASE-T
    input  wire logic                   I_TEN_MODE,         // Running 10BASE-T
    input  wire logic                   I_LINK_UP,          // Link active
    input  wire logic                   I_SWAP_CD,          // C and D crossed
    input  wire logic [3:0]             I_POL_INV,          // Inverted polarity D..A
    input  wire logic [7:0]             I_CABLE_LEN,        // Cable length meters
    input  wire logic                   I_DSCR_ACQ_FAIL,    // Descrambler acquire failed
    input  wire logic                   I_DSCR_ACQ_OK,      // Descrambler acquired
    output logic                        O_SPEED_FALLBACK    // Ask for 100/10 negotiation
);
    // Stored analysis results, one entry per pair
    logic [1:0] ftype [4];
    logic [3:0] shorts [4];
    logic [7:0] fault_range_meters [4];

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pair
            logic [1:0] next_ftype;
            logic [3:0] next_shorts;
            logic [7:0] next_range;
            always_comb begin
                next_ftype  = ftype[p];
                next_shorts = shorts[p];
                next_range  = fault_range_meters[p];
                if (I_TDR_DONE) begin
                    next_ftype  = I_TDR_FAULT_TYPE[2*p +: 2];
                    next_shorts = I_TDR_SHORTS[4*p +: 4];
                    next_range  = I_TDR_RANGE[8*p +: 8];
                end
            end
            always_ff @(posedge I_MCLK) begin
                if (I_RST) begin
                    ftype[p]              <= `CDS_FTYPE_RST;
                    shorts[p]             <= `CDS_SHORT_RST;
                    fault_range_meters[p] <= `CDS_DIST_RST;
                end else begin
                    ftype[p]              <= next_ftype;
                    shorts[p]             <= next_shorts;
                    fault_range_meters[p] <= next_range;
                end
            end
        end
    endgenerate

    // Skew flag and start pair
    logic       skew;
    logic       next_skew;
    logic [1:0] start_pair;
    logic [1:0] next_start_pair;

    // Bus handshake
    cds_pkg::cds_bus_state_t state;
    cds_pkg::cds_bus_state_t next_state;
    logic [31:0]             next_readdata;
    logic                    rd_tdr;
    logic                    next_rd_tdr;

    cds_pkg::cds_pair_t pair;
    logic               hit_status;
    logic               hit_ctrl;
    logic               take;
    logic               advance;
    logic [15:0]        tdr_word;
    logic [15:0]        link_word;
    logic [7:0]         range_eff;
    logic [1:0]         cur_ftype;
    logic [3:0]         cur_shorts;

    assign hit_status = (I_AVS_ADDRESS == `CDS_ADDR_STATUS);
    assign hit_ctrl   = (I_AVS_ADDRESS == `CDS_ADDR_CTRL);
    assign take       = (state == cds_pkg::BUS_IDLE) && (I_AVS_READ || I_AVS_WRITE);
    // Advance at the completing edge so one read sees one pair throughout
    assign advance    = (state == cds_pkg::BUS_ACK) && I_AVS_READ && rd_tdr;  // [RULE_17]

    assign cur_ftype  = ftype[pair];
    assign cur_shorts = shorts[pair];                                          // [RULE_01]

    always_comb begin
        range_eff = fault_range_meters[pair];                                  // [RULE_03]
        if (cur_ftype == `CDS_FTYPE_INVALID) begin
            range_eff = `CDS_DIST_UNKNOWN;                                     // [RULE_15]
        end
        // Shorts D..A in bits 13:10, distance 9:2, pair 1:0
        tdr_word = {cur_ftype, cur_shorts, range_eff, pair};   // [RULE_14] [RULE_16] [RULE_04]
    end

    always_comb begin
        link_word = 16'h0000;
        link_word[`CDS_BIT_SWAP_CD] = I_GIG_MODE && I_SWAP_CD;                 // [RULE_08]
        link_word[`CDS_BIT_POL_D]   = I_GIG_MODE && I_POL_INV[3];              // [RULE_09]
        link_word[`CDS_BIT_POL_C]   = I_GIG_MODE && I_POL_INV[2];              // [RULE_09]
        link_word[`CDS_BIT_POL_B]   = (I_GIG_MODE || I_TEN_MODE) && I_POL_INV[1]; // [RULE_10]
        link_word[`CDS_BIT_POL_A]   = (I_GIG_MODE || I_TEN_MODE) && I_POL_INV[0]; // [RULE_10]
        // No link means no measurement, reported as unknown
        link_word[9:2] = I_LINK_UP ? I_CABLE_LEN : `CDS_DIST_UNKNOWN;         // [RULE_11]
        link_word[`CDS_BIT_SKEW] = skew;                                       // [RULE_12]
    end

    always_comb begin
        // A new failure in the same cycle as a good acquisition keeps the flag
        next_skew = skew;
        if (I_DSCR_ACQ_FAIL) begin
            next_skew = 1'b1;                                                  // [RULE_12]
        end else if (I_DSCR_ACQ_OK) begin
            next_skew = 1'b0;
        end
        next_start_pair = start_pair;
        // Commit at the acknowledge edge, where the master sees the write complete
        if ((state == cds_pkg::BUS_ACK) && I_AVS_WRITE && hit_ctrl && I_AVS_BYTEENABLE[1]) begin
            next_start_pair = I_AVS_WRITEDATA[`CDS_START_MSB:`CDS_START_LSB]; // [RULE_05]
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            skew       <= 1'b0;
            start_pair <= `CDS_START_RST;
        end else begin
            skew       <= next_skew;
            start_pair <= next_start_pair;
        end
    end

    always_comb begin
        next_state    = state;
        next_readdata = O_AVS_READDATA;
        next_rd_tdr   = rd_tdr;
        case (state)
            cds_pkg::BUS_IDLE: begin
                if (take) begin
                    next_state    = cds_pkg::BUS_ACK;
                    next_rd_tdr   = I_AVS_READ && hit_status && !I_LINK_EN;
                    next_readdata = 32'h0000_0000;
                    if (I_AVS_READ && hit_status) begin
                        next_readdata = {16'h0000, I_LINK_EN ? link_word : tdr_word}; // [RULE_07]
                    end else if (I_AVS_READ && hit_ctrl) begin
                        next_readdata[`CDS_START_MSB:`CDS_START_LSB] = start_pair;
                    end
                end
            end
            cds_pkg::BUS_ACK: begin
                next_state  = cds_pkg::BUS_IDLE;
                next_rd_tdr = 1'b0;
            end
            default: begin
                next_state  = cds_pkg::BUS_IDLE;
                next_rd_tdr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state          <= cds_pkg::BUS_IDLE;
            O_AVS_READDATA <= 32'h0000_0000;
            rd_tdr         <= 1'b0;
        end else begin
            state          <= next_state;
            O_AVS_READDATA <= next_readdata;
            rd_tdr         <= next_rd_tdr;
        end
    end

    // Released only in the acknowledge cycle
    assign O_AVS_WAITREQUEST = (state == cds_pkg::BUS_IDLE);
    // Skew blocks gigabit, so the negotiator drops to the lower speeds
    assign O_SPEED_FALLBACK  = skew;                                           // [RULE_13]

    cds_pair_cursor u_cursor (
        .i_clk     (I_MCLK),
        .i_rst     (I_RST),
        .i_load    (I_TDR_DONE),
        .i_start   (start_pair),
        .i_advance (advance),
        .o_pair    (pair)          // [RULE_06]
    );

    logic tdr_rd;
    assign tdr_rd = take && I_AVS_READ && hit_status && !I_LINK_EN;

    property p_short_a;
        @(posedge I_MCLK) disable iff (I_RST)
        tdr_rd |=> (O_AVS_READDATA[`CDS_BIT_SHORT_A] == $past(cur_shorts[0]));
    endproperty
    a_short_a: assert property (p_short_a) else $error("short to A bit wrong"); // [RULE_01]

    property p_pair_ind;
        @(posedge I_MCLK) disable iff (I_RST)
        tdr_rd |=> (O_AVS_READDATA[1:0] == $past(pair)) && !O_AVS_WAITREQUEST;
    endproperty
    a_pair_ind: assert property (p_pair_ind) else $error("pair field wrong"); // [RULE_06]

    property p_invalid_ff;
        @(posedge I_MCLK) disable iff (I_RST)
        (tdr_rd && cur_ftype == `CDS_FTYPE_INVALID)
            |=> (O_AVS_READDATA[9:2] == `CDS_DIST_UNKNOWN)
                && (O_AVS_READDATA[15:14] == `CDS_FTYPE_INVALID);
    endproperty
    a_invalid_ff: assert property (p_invalid_ff) else $error("invalid not FF"); // [RULE_15]

    property p_shorts;
        @(posedge I_MCLK) disable iff (I_RST)
        tdr_rd |=> (O_AVS_READDATA[13:11] == $past(cur_shorts[3:1]));
    endproperty
    a_shorts: assert property (p_shorts) else $error("short bits wrong"); // [RULE_16]

    property p_hold_pair;
        @(posedge I_MCLK) disable iff (I_RST)
        (tdr_rd && !I_TDR_DONE) |=> (pair == $past(pair))
            ##1 ($past(I_TDR_DONE) || (pair == 2'($past(pair, 2) + 2'h1)));
    endproperty
    a_hold_pair: assert property (p_hold_pair) else $error("pointer moved early"); // [RULE_17]

    property p_link_pol;
        @(posedge I_MCLK) disable iff (I_RST)
        (take && I_AVS_READ && hit_status && I_LINK_EN && !I_GIG_MODE)
            |=> (O_AVS_READDATA[14:12] == 3'h0);
    endproperty
    a_link_pol: assert property (p_link_pol) else $error("gigabit-only bits set"); // [RULE_09]

    property p_len;
        @(posedge I_MCLK) disable iff (I_RST)
        (take && I_AVS_READ && hit_status && I_LINK_EN && !I_LINK_UP)
            |=> (O_AVS_READDATA[9:2] == `CDS_DIST_UNKNOWN);
    endproperty
    a_len: assert property (p_len) else $error("length not unknown"); // [RULE_11]

    property p_skew;
        @(posedge I_MCLK) disable iff (I_RST)
        I_DSCR_ACQ_FAIL |=> skew && O_SPEED_FALLBACK;
    endproperty
    a_skew: assert property (p_skew) else $error("skew not latched"); // [RULE_12]

    property p_skew_hold;
        @(posedge I_MCLK) disable iff (I_RST)
        (skew && !I_DSCR_ACQ_OK) |=> skew;
    endproperty
    a_skew_hold: assert property (p_skew_hold) else $error("skew dropped"); // [RULE_13]

    property p_range;
        @(posedge I_MCLK) disable iff (I_RST)
        (tdr_rd && cur_ftype != `CDS_FTYPE_INVALID)
            |=> (O_AVS_READDATA[9:2] == $past(fault_range_meters[pair]));
    endproperty
    a_range: assert property (p_range) else $error("fault distance wrong"); // [RULE_04]

    property p_ftype;
        @(posedge I_MCLK) disable iff (I_RST)
        tdr_rd |=> (O_AVS_READDATA[15:14] == $past(cur_ftype));
    endproperty
    a_ftype: assert property (p_ftype) else $error("fault type wrong"); // [RULE_14]

    property p_link_ab;
        @(posedge I_MCLK) disable iff (I_RST)
        (take && I_AVS_READ && hit_status && I_LINK_EN && !I_GIG_MODE && !I_TEN_MODE)
            |=> (O_AVS_READDATA[11:10] == 2'h0);
    endproperty
    a_link_ab: assert property (p_link_ab) else $error("pair A/B polarity set"); // [RULE_10]

    property p_link_rsvd;
        @(posedge I_MCLK) disable iff (I_RST)
        (take && I_AVS_READ && hit_status && I_LINK_EN)
            |=> (O_AVS_READDATA[15] == 1'b0) && (O_AVS_READDATA[1] == 1'b0);
    endproperty
    a_link_rsvd: assert property (p_link_rsvd) else $error("reserved link bits set"); // [RULE_07]

    property p_start_wr;
        @(posedge I_MCLK) disable iff (I_RST)
        ((state == cds_pkg::BUS_ACK) && I_AVS_WRITE && hit_ctrl && I_AVS_BYTEENABLE[1])
            |=> (start_pair == $past(I_AVS_WRITEDATA[`CDS_START_MSB:`CDS_START_LSB]));
    endproperty
    a_start_wr: assert property (p_start_wr) else $error("start pair not stored"); // [RULE_05]

    c_tdr_read:  cover property (@(posedge I_MCLK) disable iff (I_RST) tdr_rd ##2 tdr_rd);
    c_link_read: cover property (@(posedge I_MCLK) disable iff (I_RST)
        take && I_AVS_READ && hit_status && I_LINK_EN);
    c_ctrl_wr:   cover property (@(posedge I_MCLK) disable iff (I_RST)
        take && I_AVS_WRITE && hit_ctrl);
endmodule
`default_nettype wire

/* src/cds_cfg.svh */
// Purpose: Offsets, field positions and reset values of the cable diagnostics readout
// Assumes: Avalon-MM byte addresses are four times the register index
// Notes:   Definitions only
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH

`define CDS_ADDR_W         7
`define CDS_IDX_STATUS     5'h1F
`define CDS_IDX_CTRL       5'h1E
`define CDS_ADDR_STATUS    7'h7C
`define CDS_ADDR_CTRL      7'h78

`define CDS_START_LSB      12
`define CDS_START_MSB      13
`define CDS_START_RST      2'h0

`define CDS_FTYPE_INVALID  2'h3
`define CDS_FTYPE_OPEN     2'h2
`define CDS_FTYPE_MISMATCH 2'h1
`define CDS_FTYPE_RST      2'h3
`define CDS_SHORT_RST      4'h0
`define CDS_DIST_RST       8'h00
`define CDS_DIST_UNKNOWN   8'hFF

`define CDS_BIT_SWAP_CD    14
`define CDS_BIT_POL_D      13
`define CDS_BIT_POL_C      12
`define CDS_BIT_POL_B      11
`define CDS_BIT_POL_A      10
`define CDS_BIT_SHORT_A    10
`define CDS_BIT_SKEW       0

`endif

/* src/cds_pkg.sv */
// Purpose: Types shared by the cable diagnostics readout
// Assumes: Constants live in cds_cfg.svh
// Notes:   None
package cds_pkg;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } cds_bus_state_t;

    typedef enum logic [1:0] {
        PAIR_A = 2'b00,
        PAIR_B = 2'b01,
        PAIR_C = 2'b10,
        PAIR_D = 2'b11
    } cds_pair_t;
endpackage

/* src/cds_pair_cursor.sv */
// Purpose: Pair pointer that walks A, B, C, D across reads of the test result
// Assumes: Load and advance are single-cycle pulses on the same clock
// Notes:   Load wins over advance so a fresh analysis always restarts the walk
`timescale 1ns/1ps
`default_nettype none
module cds_pair_cursor (
    input  wire logic              i_clk,     // Management clock
    input  wire logic              i_rst,     // Synchronous reset, high
    input  wire logic              i_load,    // Analysis completed
    input  wire logic [1:0]        i_start,   // First pair to report
    input  wire logic              i_advance, // Whole read finished
    output var cds_pkg::cds_pair_t o_pair     // Pair now reported
);
    cds_pkg::cds_pair_t pair;
    cds_pkg::cds_pair_t next_pair;

    always_comb begin
        next_pair = pair;
        if (i_load) begin
            next_pair = cds_pkg::cds_pair_t'(i_start);             // [RULE_05]
        end else if (i_advance) begin
            next_pair = cds_pkg::cds_pair_t'(2'(pair + 2'h1));   // [RULE_02]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pair <= cds_pkg::PAIR_A;
        end else begin
            pair <= next_pair;
        end
    end

    assign o_pair = pair;

    property p_walk_wrap;
        @(posedge i_clk) disable iff (i_rst)
        (i_advance && !i_load) |=> (pair == 2'($past(pair) + 2'h1));
    endproperty
    a_walk_wrap: assert property (p_walk_wrap) else $error("pair did not step"); // [RULE_02]

    property p_start_pair;
        @(posedge i_clk) disable iff (i_rst)
        i_load |=> (pair == $past(i_start));
    endproperty
    a_start_pair: assert property (p_start_pair) else $error("walk not at start"); // [RULE_05]

    c_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
        (pair == cds_pkg::PAIR_D) && i_advance && !i_load);
endmodule
`default_nettype wire

/* testbench/cds_status_tb_top.sv */
// Purpose: Self-checking bench for the cable diagnostics status readout
// Assumes: Results load on a done pulse; the master waits as long as the slave stalls
// Notes:   Waitrequest and read data are sampled at the rising edge that completes a transfer
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_status_tb_top;
    logic                   mclk;
    logic                   rst;
    logic [`CDS_ADDR_W-1:0] avs_address;
    logic                   avs_read;
    logic                   avs_write;
    logic [31:0]            avs_writedata;
    logic [3:0]             avs_byteenable;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   link_en, tdr_done, gig, ten, link_up, swap_cd;
    logic [7:0]             tdr_ft;
    logic [15:0]            tdr_shorts;
    logic [31:0]            tdr_range;
    logic [3:0]             pol_inv;
    logic [7:0]             cable_len;
    logic                   acq_fail, acq_ok, fallback, exp_skew;
    logic [31:0]            rd;
    int                     error_cnt;
    int                     n_compared;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    cds_status_top cds_status_top_i (
        .I_MCLK(mclk), .I_RST(rst), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
        .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
        .I_AVS_BYTEENABLE(avs_byteenable), .O_AVS_READDATA(avs_readdata),
        .O_AVS_WAITREQUEST(avs_waitrequest), .I_LINK_EN(link_en), .I_TDR_DONE(tdr_done),
        .I_TDR_FAULT_TYPE(tdr_ft), .I_TDR_SHORTS(tdr_shorts), .I_TDR_RANGE(tdr_range),
        .I_GIG_MODE(gig), .I_TEN_MODE(ten), .I_LINK_UP(link_up), .I_SWAP_CD(swap_cd),
        .I_POL_INV(pol_inv), .I_CABLE_LEN(cable_len), .I_DSCR_ACQ_FAIL(acq_fail),
        .I_DSCR_ACQ_OK(acq_ok), .O_SPEED_FALLBACK(fallback)
    );

    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request stands until waitrequest is sampled low at a rising edge; only the watchdog
    // ends a stall
    task automatic bus_xfer(input logic wr, input logic [6:0] a, input logic [31:0] wd);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic chk_rd(input logic [6:0] a, input logic [15:0] exp);
        bus_xfer(1'b0, a, 32'h0000_0000);
        cmp32(rd, {16'h0000, exp});
    endtask

    task automatic evt(input logic d, input logic f, input logic o);
        @(posedge mclk);
        tdr_done <= d;
        acq_fail <= f;
        acq_ok   <= o;
        @(posedge mclk);
        tdr_done <= 1'b0;
        acq_fail <= 1'b0;
        acq_ok   <= 1'b0;
    endtask

    function automatic logic [15:0] exp_tdr(input logic [1:0] p);
        logic [1:0] ft;
        ft = tdr_ft[2*p +: 2];
        return {ft, tdr_shorts[4*p +: 4], (ft == 2'h3) ? 8'hFF : tdr_range[8*p +: 8], p};
    endfunction

    function automatic logic [15:0] exp_link();
        logic [15:0] r;
        r = 16'h0000;
        r[14] = gig & swap_cd;
        r[13:12] = gig ? pol_inv[3:2] : 2'h0;
        r[11:10] = (gig | ten) ? pol_inv[1:0] : 2'h0;
        r[9:2] = link_up ? cable_len : 8'hFF;
        r[0] = exp_skew;
        return r;
    endfunction

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        {link_en, tdr_done, gig, ten, link_up, swap_cd, acq_fail, acq_ok} = '0;
        {tdr_ft, tdr_shorts, tdr_range, pol_inv, cable_len} = '0;
        exp_skew = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        chk_rd(`CDS_ADDR_STATUS, 16'hC3FC);
        chk_rd(`CDS_ADDR_CTRL, 16'h0000);
        chk_rd(7'h00, 16'h0000);
        // Pairs A..D: open, mismatch, invalid, open; one short bit each
        tdr_ft     <= 8'b10_11_01_10;
        tdr_shorts <= 16'h8421;
        tdr_range  <= 32'hFE77_0012;
        evt(1'b1, 1'b0, 1'b0);
        bus_xfer(1'b1, `CDS_ADDR_STATUS, 32'h0000_FFFF);
        for (int k = 0; k < 5; k++)
            chk_rd(`CDS_ADDR_STATUS, exp_tdr(2'(k)));
        // A link-view read in between must not move the pair pointer
        link_en <= 1'b1;
        gig <= 1'b1;
        link_up <= 1'b1;
        swap_cd <= 1'b1;
        pol_inv <= 4'hA;
        cable_len <= 8'h3C;
        chk_rd(`CDS_ADDR_STATUS, 16'h68F0);
        link_en <= 1'b0;
        chk_rd(`CDS_ADDR_STATUS, exp_tdr(2'h1));
        for (int s = 1; s < 4; s++) begin
            bus_xfer(1'b1, `CDS_ADDR_CTRL, 32'(s) << 12);
            chk_rd(`CDS_ADDR_CTRL, 16'(s) << 12);
            tdr_ft <= tdr_ft ^ 8'h55;
            tdr_range <= tdr_range + 32'h0101_0101;
            evt(1'b1, 1'b0, 1'b0);
            for (int k = 0; k < 4; k++)
                chk_rd(`CDS_ADDR_STATUS, exp_tdr(2'(s + k)));
        end
        link_en <= 1'b1;
        pol_inv <= 4'hF;
        for (int m = 0; m < 4; m++) begin
            gig <= m[0];
            ten <= m[1] & ~m[0];
            link_up <= (m != 3);
            cable_len <= 8'h30 + 8'(m);
            @(posedge mclk);
            chk_rd(`CDS_ADDR_STATUS, exp_link());
        end
        evt(1'b0, 1'b1, 1'b0);
        exp_skew = 1'b1;
        chk_rd(`CDS_ADDR_STATUS, exp_link());
        cmp1(fallback, 1'b1);
        evt(1'b0, 1'b0, 1'b1);
        exp_skew = 1'b0;
        chk_rd(`CDS_ADDR_STATUS, exp_link());
        cmp1(fallback, 1'b0);
        evt(1'b0, 1'b1, 1'b1);
        exp_skew = 1'b1;
        chk_rd(`CDS_ADDR_STATUS, exp_link());
        cmp1(fallback, 1'b1);
        // Control write without its byte lane must leave the start pair alone
        avs_byteenable <= 4'hD;
        bus_xfer(1'b1, `CDS_ADDR_CTRL, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        chk_rd(`CDS_ADDR_CTRL, 16'h3000);
        // Mid-run reset returns results, start pair and skew flag to reset values
        rst     <= 1'b1;
        link_en <= 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cmp1(fallback, 1'b0);
        chk_rd(`CDS_ADDR_STATUS, 16'hC3FC);
        chk_rd(`CDS_ADDR_CTRL, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
